// ### verilog/pwm_timer_channel.sv
// Top level: 16-bit timer channel 0 in PWM mode with Avalon-MM registers
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps

// Overview of operation
// - Run flag 0 stops counting and holds the counter value.
// - Continue-select bit chooses keep counting or stop at period match.
// - Four trigger enables; a cleared bit suppresses that compare's converter trigger.
// - Sync bit clear: counter 0 runs alone, no shared clear or preset.
// - Buffer selects 0 make C and D ordinary compare registers.
// - Pin-mode bit 1 makes pin B, C or D a PWM output.
// - External clock select 0 ignores the external clock pin.
// - Polarity bit 1 makes high the active pin level.
// - Initial-level bit 0 keeps pin inactive before first match.
// - Source field 000 counts on every system clock.
// - Clear field 001 clears counter on period match.
// - Counter increments once per tick from 0000h to FFFFh, readable and writable.
// - Counter overflow sets the overflow flag unless the period register also holds FFFFh.
// - Period register gives a period of value plus one ticks.
// - Change points B, C, D compare against counter 0 per pin.
// - Period match sets flag A; software reads then writes 0 to clear.
// - Interrupt request follows flag A only while enabled.
// - Output-disable bit 0 lets the waveform reach the pin.
module pwm_timer_channel
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Avalon-MM slave
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// External count clock pin
	input  wire logic        i_ext_clock,
	// PWM pins
	output logic [2:0]       o_pwm_pin,
	output logic [2:0]       o_pwm_pin_oe,
	// Events
	output logic             o_irq,
	output logic [3:0]       o_conv_trigger
);
	import pwm_timer_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  counter_run_control;
	logic [7:0]  converter_trigger_control;
	logic [7:0]  channel_mode_control;
	logic [7:0]  pwm_pin_mode_select;
	logic [7:0]  function_control;
	logic [7:0]  pwm_polarity_control;
	logic [7:0]  initial_output_level_control;
	logic [7:0]  count_source_and_clear_control;
	logic [15:0] channel0_counter;
	logic [15:0] period_compare;
	logic [15:0] change_point_b_compare;
	logic [15:0] change_point_c_compare;
	logic [15:0] change_point_d_compare;
	logic [7:0]  irq_enable;
	logic [7:0]  output_disable;
	logic        compare_a_flag;
	logic        overflow_flag;
	logic        flag_a_seen;
	logic        ovf_seen;

	logic          read_strobe;
	logic          write_strobe;
	logic          ext_prev;
	logic          tick;
	logic          running;
	logic          continue_sel;
	logic [15:0]   next_counter;
	match_events_t ev;
	logic [15:0]   wdata16;
	logic [7:0]    wdata8;
	pin_config_t   pin_cfg [3];

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	avalon_reg_slave bus_slave
	(
		.i_clock        (i_clock),
		.i_rst          (i_rst),
		.i_read         (i_avs_read),
		.i_write        (i_avs_write),
		.o_waitrequest  (o_avs_waitrequest),
		.o_read_strobe  (read_strobe),
		.o_write_strobe (write_strobe)
	);

	// Byte lanes: low byte for 8-bit registers, low half for 16-bit ones
	assign wdata8  = i_avs_byteenable[0] ? i_avs_writedata[7:0] : RESET_BYTE;
	assign wdata16 = i_avs_writedata[15:0];

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val, input logic [1:0] be);
		merge16 = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic wr(input logic [5:0] ofs);
		wr = write_strobe && (i_avs_address == ofs);
	endfunction : wr

	// ----------------------------------------------------------------
	// Count source and run control
	// ----------------------------------------------------------------

	// Only the undivided clock is built; other source codes stall the count
	// External pin counts only when enabled, on its rising edge
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			ext_prev <= 1'b0;
		else
			ext_prev <= i_ext_clock;
	end

	always_comb
	begin
		if (function_control[BIT_EXT_CLOCK])
			tick = i_ext_clock & ~ext_prev;
		else if (count_source_and_clear_control[POS_SOURCE +: 3] == SOURCE_UNDIVIDED)
			tick = 1'b1;
		else
			tick = 1'b0;
	end

	assign running      = counter_run_control[BIT_RUN0];
	assign continue_sel = counter_run_control[BIT_CONTINUE0];

	// Compare events; sync bit is stored but counter 1 is absent, so channel runs alone
	assign ev.match_a  = running && tick && (channel0_counter == period_compare);
	assign ev.match_b  = running && tick && (channel0_counter == change_point_b_compare);
	assign ev.match_c  = running && tick && (channel0_counter == change_point_c_compare);
	assign ev.match_d  = running && tick && (channel0_counter == change_point_d_compare);
	assign ev.overflow = running && tick && (channel0_counter == COUNT_MAX) && !ev.match_a;

	// Counter next value
	always_comb
	begin
		next_counter = channel0_counter;
		if (running && tick)
		begin
			if (ev.match_a && count_source_and_clear_control[POS_CLEAR +: 3] == CLEAR_ON_PERIOD)
				next_counter = 16'h0000;
			else
				next_counter = channel0_counter + 16'h0001;
		end
	end

	// Counter: software write wins over counting in the same cycle
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			channel0_counter <= 16'h0000;
		else if (wr(OFS_COUNTER))
			channel0_counter <= merge16(channel0_counter, wdata16, i_avs_byteenable[1:0]);
		else
			channel0_counter <= next_counter;
	end

	// Run flag: cleared by a period match when continue-select is 0
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			counter_run_control <= RESET_BYTE;
		else if (wr(OFS_RUN_CONTROL))
			counter_run_control <= wdata8;
		else if (ev.match_a && !continue_sel)
			counter_run_control[BIT_RUN0] <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Byte configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			converter_trigger_control      <= RESET_BYTE;
			channel_mode_control           <= RESET_BYTE;
			pwm_pin_mode_select            <= RESET_BYTE;
			function_control               <= RESET_FUNCTION;
			pwm_polarity_control           <= RESET_BYTE;
			initial_output_level_control   <= RESET_BYTE;
			count_source_and_clear_control <= RESET_BYTE;
			irq_enable                     <= RESET_BYTE;
			output_disable                 <= RESET_OUT_DIS;
		end
		else
		begin
			if (wr(OFS_CONV_TRIGGER))  converter_trigger_control      <= wdata8;
			if (wr(OFS_MODE_CONTROL))  channel_mode_control           <= wdata8;
			if (wr(OFS_PIN_MODE))      pwm_pin_mode_select            <= wdata8;
			if (wr(OFS_FUNCTION))      function_control               <= wdata8;
			if (wr(OFS_POLARITY))      pwm_polarity_control           <= wdata8;
			if (wr(OFS_INITIAL_LEVEL)) initial_output_level_control   <= wdata8;
			if (wr(OFS_SOURCE_CLEAR))  count_source_and_clear_control <= wdata8;
			if (wr(OFS_IRQ_ENABLE))    irq_enable                     <= wdata8;
			if (wr(OFS_OUTPUT_ENABLE)) output_disable                 <= wdata8;
		end
	end

	// Compare registers; reset to all ones so an unprogrammed channel never matches early
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			period_compare         <= RESET_WORD;
			change_point_b_compare <= RESET_WORD;
			change_point_c_compare <= RESET_WORD;
			change_point_d_compare <= RESET_WORD;
		end
		else
		begin
			if (wr(OFS_PERIOD))   period_compare         <= merge16(period_compare, wdata16, i_avs_byteenable[1:0]);
			if (wr(OFS_CHANGE_B)) change_point_b_compare <= merge16(change_point_b_compare, wdata16, i_avs_byteenable[1:0]);
			if (wr(OFS_CHANGE_C)) change_point_c_compare <= merge16(change_point_c_compare, wdata16, i_avs_byteenable[1:0]);
			if (wr(OFS_CHANGE_D)) change_point_d_compare <= merge16(change_point_d_compare, wdata16, i_avs_byteenable[1:0]);
		end
	end

	// ----------------------------------------------------------------
	// Status flags: a clear writes 0 after a read that saw the flag at 1
	// ----------------------------------------------------------------

	// Set beats clear in the same cycle, so no match is lost
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			compare_a_flag <= 1'b0;
			overflow_flag  <= 1'b0;
			flag_a_seen    <= 1'b0;
			ovf_seen       <= 1'b0;
		end
		else
		begin
			if (read_strobe && i_avs_address == OFS_STATUS)
			begin
				flag_a_seen <= compare_a_flag;
				ovf_seen    <= overflow_flag;
			end
			if (ev.match_a)
				compare_a_flag <= 1'b1;
			else if (wr(OFS_STATUS) && flag_a_seen && !wdata8[BIT_FLAG_A])
			begin
				compare_a_flag <= 1'b0;
				flag_a_seen    <= 1'b0;
			end
			if (ev.overflow)
				overflow_flag <= 1'b1;
			else if (wr(OFS_STATUS) && ovf_seen && !wdata8[BIT_OVERFLOW])
			begin
				overflow_flag <= 1'b0;
				ovf_seen      <= 1'b0;
			end
		end
	end

	// Interrupt request and converter triggers
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_irq          <= 1'b0;
			o_conv_trigger <= 4'h0;
		end
		else
		begin
			o_irq          <= compare_a_flag & irq_enable[BIT_IRQ_A];
			o_conv_trigger <= {ev.match_d, ev.match_c, ev.match_b, ev.match_a} & converter_trigger_control[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_avs_readdata <= 32'h00000000;
		else if (read_strobe)
		begin
			unique case (i_avs_address)
				OFS_RUN_CONTROL:   o_avs_readdata <= {24'h000000, counter_run_control};
				OFS_CONV_TRIGGER:  o_avs_readdata <= {24'h000000, converter_trigger_control};
				OFS_MODE_CONTROL:  o_avs_readdata <= {24'h000000, channel_mode_control};
				OFS_PIN_MODE:      o_avs_readdata <= {24'h000000, pwm_pin_mode_select};
				OFS_FUNCTION:      o_avs_readdata <= {24'h000000, function_control};
				OFS_POLARITY:      o_avs_readdata <= {24'h000000, pwm_polarity_control};
				OFS_INITIAL_LEVEL: o_avs_readdata <= {24'h000000, initial_output_level_control};
				OFS_SOURCE_CLEAR:  o_avs_readdata <= {24'h000000, count_source_and_clear_control};
				OFS_COUNTER:       o_avs_readdata <= {16'h0000, channel0_counter};
				OFS_PERIOD:        o_avs_readdata <= {16'h0000, period_compare};
				OFS_CHANGE_B:      o_avs_readdata <= {16'h0000, change_point_b_compare};
				OFS_CHANGE_C:      o_avs_readdata <= {16'h0000, change_point_c_compare};
				OFS_CHANGE_D:      o_avs_readdata <= {16'h0000, change_point_d_compare};
				OFS_STATUS:        o_avs_readdata <= {27'h0000000, overflow_flag, 3'h0, compare_a_flag};
				OFS_IRQ_ENABLE:    o_avs_readdata <= {24'h000000, irq_enable};
				OFS_OUTPUT_ENABLE: o_avs_readdata <= {24'h000000, output_disable};
				default:           o_avs_readdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// PWM pin stages B, C, D
	// ----------------------------------------------------------------
	assign pin_cfg[0] = '{pwm_pin_mode_select[0], pwm_polarity_control[0], initial_output_level_control[1],
		output_disable[POS_OUT_DISABLE], change_point_b_compare};
	assign pin_cfg[1] = '{pwm_pin_mode_select[1], pwm_polarity_control[1], initial_output_level_control[2],
		output_disable[POS_OUT_DISABLE + 1], change_point_c_compare};
	assign pin_cfg[2] = '{pwm_pin_mode_select[2], pwm_polarity_control[2], initial_output_level_control[3],
		output_disable[POS_OUT_DISABLE + 2], change_point_d_compare};

	generate
		for (genvar p = 0; p < 3; p++)
		begin : g_pin
			pwm_pin_stage stage
			(
				.i_clock        (i_clock),
				.i_rst          (i_rst),
				.i_config       (pin_cfg[p]),
				.i_running      (running),
				.i_tick         (tick),
				.i_match        (p == 0 ? ev.match_b : (p == 1 ? ev.match_c : ev.match_d)),
				.i_period_match (ev.match_a),
				.o_pin          (o_pwm_pin[p]),
				.o_pin_oe       (o_pwm_pin_oe[p])
			);
		end
	endgenerate

endmodule : pwm_timer_channel

// ### verilog/pwm_timer_pkg.sv
// Package: register map, field positions, reset values and types of the PWM timer channel
package pwm_timer_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_RUN_CONTROL   = 6'h00;
	localparam logic [5:0] OFS_CONV_TRIGGER  = 6'h04;
	localparam logic [5:0] OFS_MODE_CONTROL  = 6'h08;
	localparam logic [5:0] OFS_PIN_MODE      = 6'h0C;
	localparam logic [5:0] OFS_FUNCTION      = 6'h10;
	localparam logic [5:0] OFS_POLARITY      = 6'h14;
	localparam logic [5:0] OFS_INITIAL_LEVEL = 6'h18;
	localparam logic [5:0] OFS_SOURCE_CLEAR  = 6'h1C;
	localparam logic [5:0] OFS_COUNTER       = 6'h20;
	localparam logic [5:0] OFS_PERIOD        = 6'h24;
	localparam logic [5:0] OFS_CHANGE_B      = 6'h28;
	localparam logic [5:0] OFS_CHANGE_C      = 6'h2C;
	localparam logic [5:0] OFS_CHANGE_D      = 6'h30;
	localparam logic [5:0] OFS_STATUS        = 6'h34;
	localparam logic [5:0] OFS_IRQ_ENABLE    = 6'h38;
	localparam logic [5:0] OFS_OUTPUT_ENABLE = 6'h3C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_RUN0          = 0;
	localparam int BIT_CONTINUE0     = 2;
	localparam int BIT_SYNC          = 0;
	localparam int BIT_BUF_C         = 4;
	localparam int BIT_BUF_D         = 5;
	localparam int BIT_EXT_CLOCK     = 6;
	localparam int BIT_THREE_PHASE   = 7;
	localparam int POS_SOURCE        = 0;
	localparam int POS_CLEAR         = 5;
	localparam int BIT_FLAG_A        = 0;
	localparam int BIT_OVERFLOW      = 4;
	localparam int BIT_IRQ_A         = 0;
	localparam int POS_OUT_DISABLE   = 1;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  SOURCE_UNDIVIDED = 3'h0;
	localparam logic [2:0]  CLEAR_ON_PERIOD  = 3'h1;
	localparam logic [7:0]  RESET_BYTE       = 8'h00;
	localparam logic [7:0]  RESET_FUNCTION   = 8'h80;
	localparam logic [7:0]  RESET_OUT_DIS    = 8'h0F;
	localparam logic [15:0] RESET_WORD       = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX        = 16'hFFFF;

	// Bus answer: read data comes one cycle after the request is seen
	typedef enum logic [2:0]
	{
		BUS_IDLE = 3'b001,
		BUS_ACK  = 3'b010,
		BUS_DONE = 3'b100
	} bus_state_t;

	// Per-pin compare configuration handed to each output stage
	typedef struct packed
	{
		logic        pwm_enable;
		logic        polarity;
		logic        initial_level;
		logic        output_disable;
		logic [15:0] change_point;
	} pin_config_t;

	// Match events of one count tick
	typedef struct packed
	{
		logic match_a;
		logic match_b;
		logic match_c;
		logic match_d;
		logic overflow;
	} match_events_t;

endpackage : pwm_timer_pkg

// ### verilog/pwm_pin_stage.sv
// PWM output stage for one change-point pin
`timescale 1ns/10ps

module pwm_pin_stage
(
	// Clock and reset
	input  wire logic                       i_clock,
	input  wire logic                       i_rst,
	// Configuration and events
	input  wire pwm_timer_pkg::pin_config_t i_config,
	input  wire logic                       i_running,
	input  wire logic                       i_tick,
	input  wire logic                       i_match,
	input  wire logic                       i_period_match,
	// Pin
	output logic                            o_pin,
	output logic                            o_pin_oe
);
	import pwm_timer_pkg::*;

	logic active;

	// Active state: set at own change point, cleared at period match
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			active <= 1'b0;
		else if (!i_running)
			active <= i_config.initial_level;
		else if (i_tick && i_config.pwm_enable && i_match)
			active <= 1'b1;
		else if (i_tick && i_config.pwm_enable && i_period_match)
			active <= 1'b0;
	end

	// Pin level: polarity 1 means high is the active level
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_pin    <= 1'b0;
			o_pin_oe <= 1'b0;
		end
		else
		begin
			o_pin    <= i_config.polarity ? active : ~active;
			o_pin_oe <= i_config.pwm_enable & ~i_config.output_disable;
		end
	end

endmodule : pwm_pin_stage

// ### verilog/avalon_reg_slave.sv
// Avalon-MM slave handshake: decodes a request into one-cycle strobes
`timescale 1ns/10ps

module avalon_reg_slave
(
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// Avalon-MM request
	input  wire logic       i_read,
	input  wire logic       i_write,
	// Strobes to the register file
	output logic            o_waitrequest,
	output logic            o_read_strobe,
	output logic            o_write_strobe
);
	import pwm_timer_pkg::*;

	bus_state_t state;

	// An access arriving in IDLE waits one cycle, then is released; DONE lets the master drop the request
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			state <= BUS_IDLE;
		else
		begin
			unique case (state)
				BUS_IDLE: if (i_read || i_write) state <= BUS_ACK;
				BUS_ACK:  state <= BUS_DONE;
				BUS_DONE: state <= BUS_IDLE;
			endcase
		end
	end

	// Waitrequest drops in the ACK cycle only
	assign o_waitrequest  = (state != BUS_ACK);
	// Read data latch as the request is taken, so they stand through the answer cycle
	assign o_read_strobe  = (state == BUS_IDLE) && i_read;
	assign o_write_strobe = (state == BUS_ACK) && i_write;

endmodule : avalon_reg_slave

// ### dv/pwm_timer_props.sv
// Checker: bus handshake and output relations of the PWM timer channel
`timescale 1ns/10ps
module pwm_timer_props
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Bus
	input  wire logic [5:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	// Pins and events
	input  wire logic [2:0]  o_pwm_pin,
	input  wire logic [2:0]  o_pwm_pin_oe,
	input  wire logic        o_irq,
	input  wire logic [3:0]  o_conv_trigger
);
	import pwm_timer_pkg::*;
	logic [2:0] pm;
	logic [2:0] dis;
	logic [3:0] ten;
	logic       ien;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	// Shadow of the settings that gate the outputs, updated on completed writes
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pm  <= 3'h0;
			dis <= 3'h7;
			ten <= 4'h0;
			ien <= 1'b0;
		end
		else if (i_avs_write && !o_avs_waitrequest)
		begin
			if (i_avs_address == OFS_PIN_MODE) pm <= i_avs_writedata[2:0];
			if (i_avs_address == OFS_OUTPUT_ENABLE) dis <= i_avs_writedata[3:1];
			if (i_avs_address == OFS_CONV_TRIGGER) ten <= i_avs_writedata[3:0];
			if (i_avs_address == OFS_IRQ_ENABLE) ien <= i_avs_writedata[0];
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	wait_single_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for two cycles");
	req_answer_a: assert property ((i_avs_read || i_avs_write) |-> ##[0:2] !o_avs_waitrequest)
		else $error("request not answered");
	idle_wait_a: assert property (!$past(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
		else $error("answer without request");
	rdata_hold_a: assert property (!$past(i_avs_read) |-> $stable(o_avs_readdata))
		else $error("read data changed without a read");
	oe_config_a: assert property (pm == $past(pm) && dis == $past(dis) |-> o_pwm_pin_oe == (pm & ~dis))
		else $error("pin enable does not follow settings");
	irq_gate_a: assert property (o_irq |-> $past(ien))
		else $error("interrupt while disabled");
	trig_gate_a: assert property ((o_conv_trigger & ~($past(ten) | $past(ten, 2))) == 4'h0)
		else $error("trigger while disabled");
	trig_pulse_a: assert property ((o_conv_trigger & $past(o_conv_trigger)) == 4'h0)
		else $error("trigger wider than one cycle");
	// Main scenarios reached
	cover property ($rose(o_irq));
	cover property (o_conv_trigger[0]);
	cover property (o_pwm_pin[0] && o_pwm_pin_oe[0]);
endmodule : pwm_timer_props

bind pwm_timer_channel pwm_timer_props u_props (.i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
	.i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_pwm_pin, .o_pwm_pin_oe, .o_irq, .o_conv_trigger);

// ### dv/pwm_load_model.sv
// Partner: loads on the PWM pins that count high cycles, and a free external clock
`timescale 1ns/10ps
module pwm_load_model
(
	// Clock and control
	input  wire logic        i_clock,
	input  wire logic        i_clear,
	// Pins
	input  wire logic [2:0]  i_pin,
	input  wire logic [2:0]  i_pin_oe,
	// Results
	output logic             o_ext_clock,
	output logic [2:0][7:0]  o_high_count
);
	logic [2:0] line;
	// A pin that is not driven sits on its pull-down
	assign line = i_pin & i_pin_oe;
	// Count high cycles; the external clock toggles so a wrongly chosen source shows up
	always_ff @(posedge i_clock)
	begin
		o_ext_clock <= i_clear ? 1'b0 : ~o_ext_clock;
		for (int k = 0; k < 3; k++)
			o_high_count[k] <= i_clear ? 8'h00 : o_high_count[k] + 8'(line[k]);
	end
endmodule : pwm_load_model

// ### dv/pwm_timer_channel_tb.sv
// Testbench: registers, PWM waveforms, triggers and flags of the timer channel
`timescale 1ns/10ps
`define CHK(g, e) \
	begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module pwm_timer_channel_tb;
	import pwm_timer_pkg::*;
	logic            i_clock, i_rst, rd, wr, clear, wait_n, irq, ext_clock;
	logic [5:0]      addr;
	logic [31:0]     wdata, rdata, q;
	logic [2:0]      pin, oe;
	logic [3:0]      trig, seen;
	logic [2:0][7:0] high;
	int              num_errors = 0;
	int              tests_run = 0;
	// Clock
	initial
	begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end
	pwm_timer_channel u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(q),
		.o_avs_waitrequest(wait_n), .i_ext_clock(ext_clock), .o_pwm_pin(pin), .o_pwm_pin_oe(oe),
		.o_irq(irq), .o_conv_trigger(trig));
	pwm_load_model u_load (.i_clock(i_clock), .i_clear(clear), .i_pin(pin), .i_pin_oe(oe),
		.o_ext_clock(ext_clock), .o_high_count(high));
	// Triggers seen since the last clear
	always @(posedge i_clock)
		seen <= clear ? 4'h0 : seen | trig;
	// ----------------------------------------------------------------
	// Bus and helpers
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		addr <= a;
		wr <= w;
		rd <= ~w;
		wdata <= d;
		// Hold the request until waitrequest is sampled low at a rising edge
		do
		begin
			@(posedge i_clock);
			n++;
		end
		while (wait_n !== 1'b0 && n < 20);
		rdata = q;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20)
		begin
			num_errors++;
			conclude();
		end
	endtask : bus
	// Let the waveform settle, then count a window of ten periods
	task automatic measure;
		repeat (12) @(posedge i_clock);
		clear <= 1'b1;
		@(posedge i_clock);
		clear <= 1'b0;
		repeat (100) @(posedge i_clock);
		@(negedge i_clock);
	endtask : measure
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset;
		bus(0, OFS_FUNCTION, 0);
		`CHK(rdata[7:0], RESET_FUNCTION)
		bus(0, OFS_OUTPUT_ENABLE, 0);
		`CHK(rdata[7:0], RESET_OUT_DIS)
		bus(0, OFS_PERIOD, 0);
		`CHK(rdata[15:0], RESET_WORD)
		bus(0, OFS_COUNTER, 0);
		`CHK(rdata[15:0], 16'h0000)
		bus(0, 6'h02, 0);
		`CHK(rdata, 32'h00000000)
		$display("test_reset done");
	endtask : test_reset
	// Period 10 ticks, change points 2, 4, 6, all high active
	task automatic test_pwm;
		bus(1, OFS_CONV_TRIGGER, 32'h0F);
		bus(1, OFS_MODE_CONTROL, 32'h00);
		bus(1, OFS_PIN_MODE, 32'h07);
		bus(1, OFS_FUNCTION, 32'h80);
		bus(1, OFS_POLARITY, 32'h07);
		bus(1, OFS_INITIAL_LEVEL, 32'h00);
		bus(1, OFS_SOURCE_CLEAR, 32'h20);
		bus(1, OFS_COUNTER, 32'h0);
		bus(1, OFS_PERIOD, 32'h9);
		bus(1, OFS_CHANGE_B, 32'h2);
		bus(1, OFS_CHANGE_C, 32'h4);
		bus(1, OFS_CHANGE_D, 32'h6);
		bus(1, OFS_OUTPUT_ENABLE, 32'h01);
		bus(1, OFS_IRQ_ENABLE, 32'h01);
		bus(0, OFS_PIN_MODE, 0);
		`CHK(rdata[7:0], 8'h07)
		bus(1, OFS_RUN_CONTROL, 32'h05);
		measure();
		`CHK(oe, 3'h7)
		`CHK(high[0], 8'd70)
		`CHK(high[1], 8'd50)
		`CHK(high[2], 8'd30)
		`CHK(seen, 4'hF)
		`CHK(irq, 1'b1)
		$display("test_pwm done");
	endtask : test_pwm
	task automatic test_flags;
		logic [15:0] held;
		bus(1, OFS_IRQ_ENABLE, 32'h00);
		repeat (2) @(negedge i_clock);
		`CHK(irq, 1'b0)
		bus(1, OFS_RUN_CONTROL, 32'h04);
		bus(0, OFS_COUNTER, 0);
		held = rdata[15:0];
		repeat (8) @(posedge i_clock);
		`CHK(pin, 3'h0)
		bus(0, OFS_COUNTER, 0);
		`CHK(rdata[15:0], held)
		bus(0, OFS_STATUS, 0);
		`CHK(rdata[BIT_FLAG_A], 1'b1)
		bus(1, OFS_STATUS, 32'h0);
		bus(1, OFS_IRQ_ENABLE, 32'h01);
		bus(0, OFS_STATUS, 0);
		`CHK(rdata[BIT_FLAG_A], 1'b0)
		`CHK(irq, 1'b0)
		$display("test_flags done");
	endtask : test_flags
	// Pin B low active, pin D disabled, only trigger A enabled
	task automatic test_variant;
		bus(1, OFS_CONV_TRIGGER, 32'h01);
		bus(1, OFS_POLARITY, 32'h06);
		bus(1, OFS_OUTPUT_ENABLE, 32'h09);
		bus(1, OFS_COUNTER, 32'h0);
		bus(1, OFS_RUN_CONTROL, 32'h05);
		measure();
		`CHK(oe, 3'h3)
		`CHK(high[0], 8'd30)
		`CHK(high[1], 8'd50)
		`CHK(high[2], 8'd0)
		`CHK(seen, 4'h1)
		$display("test_variant done");
	endtask : test_variant
	task automatic test_overflow;
		bus(1, OFS_RUN_CONTROL, 32'h04);
		bus(1, OFS_SOURCE_CLEAR, 32'h00);
		bus(1, OFS_COUNTER, 32'hFFF0);
		bus(1, OFS_RUN_CONTROL, 32'h05);
		repeat (40) @(posedge i_clock);
		bus(1, OFS_RUN_CONTROL, 32'h04);
		bus(0, OFS_STATUS, 0);
		`CHK(rdata[BIT_OVERFLOW], 1'b1)
		bus(0, OFS_COUNTER, 0);
		`CHK(rdata[15:8], 8'h00)
		bus(1, OFS_SOURCE_CLEAR, 32'h20);
		bus(1, OFS_COUNTER, 32'h0);
		bus(1, OFS_RUN_CONTROL, 32'h01);
		repeat (30) @(posedge i_clock);
		bus(0, OFS_RUN_CONTROL, 0);
		`CHK(rdata[7:0], 8'h00)
		$display("test_overflow done");
	endtask : test_overflow
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	// Watchdog: the scenarios need a few hundred cycles
	initial
	begin
		#100000;
		num_errors++;
		conclude();
	end
	// Main sequence
	initial
	begin
		i_rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		addr = 6'h00;
		wdata = 32'h0;
		clear = 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		clear <= 1'b0;
		test_reset();
		test_pwm();
		test_flags();
		test_variant();
		test_overflow();
		conclude();
	end
endmodule : pwm_timer_channel_tb
